// file: rtl/wdt_clkdiv.sv
// Odd-ratio divider that turns oscillator edges into counting-clock ticks.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module wdt_clkdiv (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Oscillator edge and ratio
  input  wire logic       osc_edge_i,
  input  wire logic [2:0] sel_i,
  // Counting-clock tick
  output logic            tick_o
);

  wdt_pkg::wdt_div_state_s st_ff;
  wdt_pkg::wdt_div_state_s nxt_st;
  logic [3:0]              ratio;

  // Ratio 2*sel+1 gives 1, 3, 5 ... 15 without a table.
  assign ratio = {sel_i, 1'b1};

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (osc_edge_i) begin
      if (st_ff.cnt >= ratio - 4'h1) begin
        nxt_st.cnt  = 4'h0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

  div_ratio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (osc_edge_i && st_ff.cnt == ratio - 4'h1) |=> (tick_o && st_ff.cnt == 4'h0))
    else $error("divider did not tick at the selected ratio");

  div_no_early_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (osc_edge_i && st_ff.cnt < ratio - 4'h1) |=> !tick_o)
    else $error("divider ticked before the ratio was reached");

endmodule
`default_nettype wire

// file: rtl/wdt_map.svh
// Register map, field positions, widths and timing figures of the watchdog timebase.
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Word indices of the registers (byte address is four times the index).
`define WDT_IDX_CLKDIV  6'h00
`define WDT_IDX_CTRL    6'h01
`define WDT_IDX_CMD     6'h02
`define WDT_IDX_STATUS  6'h03
`define WDT_IDX_IRQCLR  6'h04
`define WDT_IDX_IRQEN   6'h05
`define WDT_IDX_COUNT   6'h06

// Clock divider register fields.
`define WDT_CD_SEL0     0
`define WDT_CD_SEL1     1
`define WDT_CD_EWIE     2
`define WDT_CD_EWF      3
`define WDT_CD_SEL2     4

// Control register fields.
`define WDT_CT_PSC_LSB  0
`define WDT_CT_PSC_MSB  3
`define WDT_CT_WDE      4
`define WDT_CT_WDIE     5
`define WDT_CT_TOF      7

// Command, status and interrupt fields.
`define WDT_CMD_RESTART 0
`define WDT_ST_EW       0
`define WDT_ST_TO       1

// Widths and limits.
`define WDT_CNT_W       22
`define WDT_PSC_MAX     4'h9
`define WDT_OSC_HZ      128000
`define WDT_EW_MIN_MS   16
`define WDT_TO_MIN_MS   32
`define WDT_EW_BASE     (`WDT_EW_MIN_MS * `WDT_OSC_HZ / 1000)

`endif

// file: rtl/wdt_pkg.sv
// Types shared by the watchdog timebase modules.
`default_nettype none
`include "wdt_map.svh"
package wdt_pkg;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } wdt_div_state_s;

  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    logic                  prev;
    logic [2:0]            div_sel;
    logic                  ew_ien;
    logic                  ew_flag;
    logic [3:0]            psc;
    logic                  wde;
    logic                  wdie;
    logic                  to_flag;
    logic [1:0]            sts;
    logic [1:0]            ien;
    logic [`WDT_CNT_W-1:0] cnt;
    logic                  ack;
    logic [31:0]           dat;
    logic                  irq;
    logic                  rst_req;
  } wdt_state_s;

endpackage
`default_nettype wire

// file: rtl/wdt_top.sv
// Watchdog timebase: oscillator divider, prescaled time-out counter and Wishbone registers.
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module wdt_top #(
  parameter int EW_BASE_CYCLES = `WDT_EW_BASE
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Oscillator pin
  input  wire logic        osc128_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Watchdog outputs
  output logic             irq_o,
  output logic             sys_rst_req_o,
  output logic             early_warning_flag_o,
  output logic             timeout_flag_o
);

  wdt_pkg::wdt_state_s   st_ff;
  wdt_pkg::wdt_state_s   nxt_st;
  logic                  osc_edge;
  logic                  tick;
  logic                  req;
  logic                  wr;
  logic [5:0]            idx;
  logic                  restart;
  logic                  running;
  logic [`WDT_CNT_W-1:0] lim;
  logic                  ew_hit;
  logic                  fin_hit;
  logic [31:0]           rdata;

  // Reserved codes are clamped to the longest interval so a stray write cannot shorten it.
  function automatic logic [`WDT_CNT_W-1:0] ew_limit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `WDT_PSC_MAX) ? `WDT_PSC_MAX : code;
    return `WDT_CNT_W'(EW_BASE_CYCLES) << c;
  endfunction

  // The first synchroniser stage feeds only the second; the edge is taken after it.
  assign osc_edge = st_ff.sync2 & ~st_ff.prev;

  wdt_clkdiv u_clkdiv (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .osc_edge_i (osc_edge),
    .sel_i      (st_ff.div_sel),
    .tick_o     (tick)
  );

  assign req     = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign wr      = req & wb_we_i & wb_sel_i[0];
  assign idx     = wb_adr_i[7:2];
  assign restart = wr && idx == `WDT_IDX_CMD && wb_dat_i[`WDT_CMD_RESTART];
  assign running = st_ff.wde | st_ff.wdie;
  assign lim     = ew_limit(st_ff.psc);
  assign ew_hit  = tick && running && !restart && st_ff.cnt == lim - `WDT_CNT_W'(1);
  assign fin_hit = tick && running && !restart && st_ff.cnt == (lim << 1) - `WDT_CNT_W'(1);

  always_comb begin
    rdata = 32'h0;
    case (idx)
      `WDT_IDX_CLKDIV: begin
        rdata[`WDT_CD_SEL0] = st_ff.div_sel[0];
        rdata[`WDT_CD_SEL1] = st_ff.div_sel[1];
        rdata[`WDT_CD_SEL2] = st_ff.div_sel[2];
        rdata[`WDT_CD_EWIE] = st_ff.ew_ien;
        rdata[`WDT_CD_EWF]  = st_ff.ew_flag;
      end
      `WDT_IDX_CTRL: begin
        rdata[`WDT_CT_PSC_MSB:`WDT_CT_PSC_LSB] = st_ff.psc;
        rdata[`WDT_CT_WDE]  = st_ff.wde;
        rdata[`WDT_CT_WDIE] = st_ff.wdie;
        rdata[`WDT_CT_TOF]  = st_ff.to_flag;
      end
      `WDT_IDX_STATUS: rdata[`WDT_ST_TO:`WDT_ST_EW] = st_ff.sts;
      `WDT_IDX_IRQEN:  rdata[`WDT_ST_TO:`WDT_ST_EW] = st_ff.ien;
      `WDT_IDX_COUNT:  rdata[`WDT_CNT_W-1:0] = st_ff.cnt;
      default:         rdata = 32'h0;
    endcase
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.sync1   = osc128_i;
    nxt_st.sync2   = st_ff.sync1;
    nxt_st.prev    = st_ff.sync2;
    nxt_st.ack     = req;
    nxt_st.rst_req = 1'b0;
    if (req) begin
      nxt_st.dat = rdata;
    end
    // Software writes first, so hardware events below win over a clear in the same cycle.
    if (wr) begin
      case (idx)
        `WDT_IDX_CLKDIV: begin
          nxt_st.div_sel = {wb_dat_i[`WDT_CD_SEL2], wb_dat_i[`WDT_CD_SEL1],
                            wb_dat_i[`WDT_CD_SEL0]};
          nxt_st.ew_ien  = wb_dat_i[`WDT_CD_EWIE];
          if (wb_dat_i[`WDT_CD_EWF]) begin
            nxt_st.ew_flag = 1'b0;
          end
        end
        `WDT_IDX_CTRL: begin
          nxt_st.psc  = wb_dat_i[`WDT_CT_PSC_MSB:`WDT_CT_PSC_LSB];
          nxt_st.wde  = wb_dat_i[`WDT_CT_WDE];
          nxt_st.wdie = wb_dat_i[`WDT_CT_WDIE];
          if (wb_dat_i[`WDT_CT_TOF]) begin
            nxt_st.to_flag = 1'b0;
          end
        end
        `WDT_IDX_IRQCLR: nxt_st.sts = st_ff.sts & ~wb_dat_i[`WDT_ST_TO:`WDT_ST_EW];
        `WDT_IDX_IRQEN:  nxt_st.ien = wb_dat_i[`WDT_ST_TO:`WDT_ST_EW];
        default: begin
        end
      endcase
    end
    // Stopped mode holds the counter at zero so enabling always starts a full interval.
    if (restart || !running) begin
      nxt_st.cnt = '0;
    end else if (tick) begin
      nxt_st.cnt = fin_hit ? '0 : st_ff.cnt + `WDT_CNT_W'(1);
    end
    if (ew_hit) begin
      nxt_st.sts[`WDT_ST_EW] = 1'b1;
      if (st_ff.ew_ien) begin
        nxt_st.ew_flag = 1'b1;
      end
    end
    if (fin_hit) begin
      nxt_st.sts[`WDT_ST_TO] = 1'b1;
      if (st_ff.wdie) begin
        nxt_st.to_flag = 1'b1;
      end
      // With both enables set the first expiry only interrupts and drops into reset mode.
      if (st_ff.wde && st_ff.wdie) begin
        nxt_st.wdie = 1'b0;
      end else if (st_ff.wde) begin
        nxt_st.rst_req = 1'b1;
      end
    end
    nxt_st.irq = |(nxt_st.sts & nxt_st.ien);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o             = st_ff.dat;
  assign wb_ack_o             = st_ff.ack;
  assign irq_o                = st_ff.irq;
  assign sys_rst_req_o        = st_ff.rst_req;
  assign early_warning_flag_o = st_ff.ew_flag;
  assign timeout_flag_o       = st_ff.to_flag;

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle after the request");

  sel_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `WDT_IDX_CLKDIV) |=> st_ff.div_sel ==
      {$past(wb_dat_i[`WDT_CD_SEL2]), $past(wb_dat_i[`WDT_CD_SEL1]), $past(wb_dat_i[`WDT_CD_SEL0])})
    else $error("divider selector not stored at its bit positions");

  ew_at_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && running && !restart && st_ff.psc == 4'h0 && st_ff.cnt == `WDT_CNT_W'(EW_BASE_CYCLES - 1))
      |=> st_ff.sts[`WDT_ST_EW])
    else $error("early warning missing at the base interval");

  final_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && running && !restart && st_ff.cnt == (ew_limit(st_ff.psc) << 1) - `WDT_CNT_W'(1))
      |=> (st_ff.cnt == '0 && st_ff.sts[`WDT_ST_TO]))
    else $error("final time-out not taken at twice the early-warning count");

  restart_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    restart |=> st_ff.cnt == '0)
    else $error("restart did not clear the counter");

  ew_flag_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!early_warning_flag_o && !st_ff.ew_ien) |=> !early_warning_flag_o)
    else $error("early-warning flag set with its enable off");

  reset_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fin_hit && st_ff.wde && !st_ff.wdie) |=> (sys_rst_req_o ##1 !sys_rst_req_o))
    else $error("reset request not a one-cycle pulse after final time-out");

  irq_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fin_hit && st_ff.wdie) |=> (timeout_flag_o && !sys_rst_req_o))
    else $error("time-out flag missing in interrupt mode");

  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_ff.sts[`WDT_ST_TO]) && st_ff.ien[`WDT_ST_TO] |-> irq_o)
    else $error("enabled status bit did not raise the interrupt");

  both_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fin_hit && st_ff.wde && st_ff.wdie) |=> (!st_ff.wdie && timeout_flag_o && !sys_rst_req_o))
    else $error("interrupt-and-reset mode did not fall back to reset mode");

  ew_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ew_hit && st_ff.ew_ien) |=> early_warning_flag_o)
    else $error("early-warning flag not set at the first time-out");

  tick_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && running && !restart && !fin_hit) |=> st_ff.cnt == $past(st_ff.cnt) + `WDT_CNT_W'(1))
    else $error("counter did not advance on a counting-clock tick");

  // Stopped mode must not age the counter, or a later enable would give a short first interval.
  stopped_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !running |=> st_ff.cnt == '0)
    else $error("counter moved while the watchdog was stopped");

endmodule
`default_nettype wire

// file: testbench/test_watchdog_clock_divider_prescaler.sv
// Self-checking bench for the watchdog timebase: registers, divider ratios, time-outs and interrupt.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_clock_divider_prescaler;
  logic        clk_i;
  logic        rst_i;
  logic        osc128_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        sys_rst_req_o;
  logic        early_warning_flag_o;
  logic        timeout_flag_o;
  int          errors;
  int          cmp_count;
  int          rst_cnt = 0;
  logic [31:0] rdat;
  int          codes [8] = '{9, 0, 1, 2, 0, 1, 0, 0};

  wdt_top #(.EW_BASE_CYCLES(4)) u_dut (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .osc128_i             (osc128_i),
    .wb_cyc_i             (wb_cyc_i),
    .wb_stb_i             (wb_stb_i),
    .wb_we_i              (wb_we_i),
    .wb_adr_i             (wb_adr_i),
    .wb_sel_i             (wb_sel_i),
    .wb_dat_i             (wb_dat_i),
    .wb_dat_o             (wb_dat_o),
    .wb_ack_o             (wb_ack_o),
    .irq_o                (irq_o),
    .sys_rst_req_o        (sys_rst_req_o),
    .early_warning_flag_o (early_warning_flag_o),
    .timeout_flag_o       (timeout_flag_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // The reset request is a one-cycle pulse, so it is counted rather than sampled.
  always @(posedge clk_i) begin
    if (sys_rst_req_o === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
    end
  end

  task automatic conclude();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Ack is sampled at the rising edge, and the read data is taken at that same edge.
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) begin
        errors++;
        conclude();
      end
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0, 4'hf);
    chk(rdat, exp);
  endtask

  // Each pulse is high for four of eight system clocks, longer than the synchroniser and divider latency.
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge clk_i);
      osc128_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      osc128_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    @(negedge clk_i);
  endtask

  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge clk_i);
    chk({31'h0, irq_o}, {31'h0, exp});
  endtask

  initial begin
    int          d;
    int          lw;
    int          c0;
    logic [31:0] cd;
    logic [31:0] ct;
    errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    osc128_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    xfer(8'h00, 1'b1, 32'h13, 4'he);
    rd(8'h00, 32'h0);
    wr(8'h1c, 32'hff);
    rd(8'h1c, 32'h0);
    wr(8'h14, 32'h1);
    rd(8'h14, 32'h1);
    // The divider phase after a restart is unknown, so each bound is one divided period wide.
    for (int i = 0; i < 8; i++) begin
      d = 2 * i + 1;
      lw = 4 << codes[i];
      cd = {27'h0, i[2], 1'b0, 1'b1, i[1:0]};
      ct = (i[0] ? 32'h10 : 32'h20) | 32'(codes[i]);
      wr(8'h00, cd | 32'h8);
      rd(8'h00, cd);
      wr(8'h04, ct | 32'h80);
      wr(8'h10, 32'h3);
      wr(8'h08, 32'h1);
      rd(8'h18, 32'h0);
      c0 = rst_cnt;
      osc((lw - 1) * d);
      chk({30'h0, early_warning_flag_o, irq_o}, 32'h0);
      osc(d);
      chk({30'h0, early_warning_flag_o, irq_o}, 32'h3);
      osc((lw - 1) * d);
      rd(8'h0c, 32'h1);
      osc(d);
      rd(8'h0c, 32'h3);
      chk({31'h0, timeout_flag_o}, {31'h0, ~i[0]});
      chk(32'(rst_cnt - c0), 32'(i[0]));
    end
    // Interrupt-and-reset mode: the first final time-out only interrupts, the second resets.
    wr(8'h00, 32'h8);
    wr(8'h04, 32'hb0);
    wr(8'h08, 32'h1);
    c0 = rst_cnt;
    osc(3);
    rd(8'h18, 32'h3);
    wr(8'h08, 32'h1);
    rd(8'h18, 32'h0);
    osc(8);
    rd(8'h04, 32'h90);
    chk({31'h0, early_warning_flag_o}, 32'h0);
    chk(32'(rst_cnt - c0), 32'h0);
    osc(8);
    chk(32'(rst_cnt - c0), 32'h1);
    wr(8'h04, 32'h80);
    osc(3);
    rd(8'h18, 32'h0);
    wr(8'h14, 32'h0);
    chk_irq(1'b0);
    wr(8'h14, 32'h2);
    chk_irq(1'b1);
    wr(8'h10, 32'h2);
    chk_irq(1'b0);
    rd(8'h0c, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
